// >>> logic/input_filter.v
// Purpose: three-stage synchroniser with a stable-time filter
// Assumes: input is asynchronous to clk_in
// Notes: a new level is accepted after FILTER_CYCLES agreeing cycles
`timescale 1ns/1ns
module input_filter #(
  parameter integer FILTER_CYCLES = 1
)(
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Raw and cleaned level
  input wire raw_in,
  output wire clean_out
);

localparam integer CNT_W = (FILTER_CYCLES > 1) ? $clog2(FILTER_CYCLES) + 1 : 1;
localparam integer LAST_I = (FILTER_CYCLES > 1) ? FILTER_CYCLES - 1 : 0;

reg s1_r;
reg s2_r;
reg s3_r;
reg clean_r;
reg [CNT_W-1:0] cnt_r;
reg [CNT_W-1:0] cnt_nxt;
reg clean_nxt;

// ----------------------------------------
// Synchroniser
// ----------------------------------------
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    s1_r <= 1'b0;
    s2_r <= 1'b0;
    s3_r <= 1'b0;
  end
  else
  begin
    s1_r <= raw_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
end

// ----------------------------------------
// Filter
// ----------------------------------------
// Any disagreement or return to the old level restarts the wait
always @*
begin
  cnt_nxt = {CNT_W{1'b0}};
  clean_nxt = clean_r;
  if ((s2_r == s3_r) && (s3_r != clean_r))
  begin
    if (cnt_r == LAST_I[CNT_W-1:0])
      clean_nxt = s3_r;
    else
      cnt_nxt = cnt_r + 1'b1;
  end
end

always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    cnt_r <= {CNT_W{1'b0}};
    clean_r <= 1'b0;
  end
  else
  begin
    cnt_r <= cnt_nxt;
    clean_r <= clean_nxt;
  end
end

assign clean_out = clean_r;

endmodule

// >>> logic/por_and_low_voltage_detect.v
// Purpose: power-on reset sequencing and low-voltage detect logic
// Assumes: comparators, thresholds and regulator are analog, outside
// Notes: registers on AXI4-Lite, single clock clk_in
//
// Notes on behaviour
// RULE1: Reset pin low holds prescaler and chip in reset; high starts counting.
// RULE2: Internal reset stays until prescaler counts 131072 clocks, overflow releases.
// RULE3: Reset pin pulses shorter than about 100 ns are ignored.
// RULE4: After power-on reset the detector stays disabled until software enables it.
// RULE5: Software enables detector, waits 50 us, then sets reset enable.
// RULE6: Software clears reset enable before detector enable, never together.
// RULE7: Below reset level with reset enabled drives low-voltage reset low.
// RULE8: Supply back above reset level: count 131072 clocks, then release.
// RULE9: Low-voltage reset keeps detector enable, level select, reset enable.
// RULE10: Fall below fall level: interrupt signal low, fall flag, line zero request.
// RULE11: Recovery above rise level: interrupt signal high, rise flag and request.
// RULE12: Below reset level while interrupts run gives low-voltage reset.
// RULE13: On fall interrupt software saves data and enters standby in time.
// RULE14: After 50 us wait software clears both flags, then sets enables.
// RULE15: Software clears reset and interrupt enables before detector enable.
// RULE16: Supply collapse gives full power-on reset regardless of settings.
// RULE17: Flags clear only by writing zero after reading one.
// RULE18: Comparator outputs are synchronised before use.
`timescale 1ns/1ns
`include "por_lvd_defines.vh"
module por_and_low_voltage_detect #(
  parameter integer PRESCALE_CYCLES = `PRESCALE_CYCLES,
  parameter integer FILTER_CYCLES = `PIN_FILTER_CYCLES
)(
  // Clock and supply-collapse reset
  input wire clk_in,
  input wire resetn_in,
  // Pin, comparators, watchdog
  input wire ext_reset_pin_n_in,
  input wire below_reset_level_in,
  input wire below_fall_level_in,
  input wire above_rise_level_in,
  input wire watchdog_reset_in,
  // AXI4-Lite write
  input wire [`ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // AXI4-Lite read
  input wire [`ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Reset and detector outputs
  output wire internal_reset_n_out,
  output wire prescaler_overflow_out,
  output wire lowvolt_reset_n_out,
  output wire lowvolt_int_n_out,
  output wire ext_irq_line_zero_out,
  output wire detector_enable_out,
  output wire reset_level_select_out,
  output wire irq_out
);

localparam integer CNT_W = $clog2(PRESCALE_CYCLES) + 1;
localparam integer LAST_I = PRESCALE_CYCLES - 1;

function mapped;
  input [`ADDR_W-1:0] a;
  reg [`ADDR_W-1:0] w;
  begin
    w = {a[`ADDR_W-1:2], 2'b00};
    mapped = (w == `OFF_CTRL) || (w == `OFF_STAT) || (w == `OFF_EVT) ||
      (w == `OFF_MASK) || (w == `OFF_LEVEL);
  end
endfunction

// ----------------------------------------
// Input conditioning
// ----------------------------------------
wire [`IN_N-1:0] raw_w;
wire [`IN_N-1:0] clean_w;

assign raw_w[`IN_PIN] = ext_reset_pin_n_in;
assign raw_w[`IN_BELOW_RST] = below_reset_level_in;
assign raw_w[`IN_BELOW_FALL] = below_fall_level_in;
assign raw_w[`IN_ABOVE_RISE] = above_rise_level_in;

// Only the pin needs the long filter; comparators just synchronise
genvar gi;
generate
  for (gi = 0; gi < `IN_N; gi = gi + 1)
  begin : g_in
    input_filter #(
      .FILTER_CYCLES((gi == `IN_PIN) ? FILTER_CYCLES : 1)
    ) u_filt (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .raw_in(raw_w[gi]),
      .clean_out(clean_w[gi])
    ); // [RULE3] [RULE18]
  end
endgenerate

wire pin_high_w = clean_w[`IN_PIN];
wire below_rst_w = clean_w[`IN_BELOW_RST];
wire below_fall_w = clean_w[`IN_BELOW_FALL];
wire above_rise_w = clean_w[`IN_ABOVE_RISE];

// ----------------------------------------
// Control bits
// ----------------------------------------
reg det_en_r;
reg lvl_sel_r;
reg rst_en_r;
reg fall_en_r;
reg rise_en_r;

// Power-on and watchdog resets reinitialise; low-voltage reset does not
wire por_hold_w = !pin_high_w | watchdog_reset_in; // [RULE1] [RULE9]
wire irq_func_w = det_en_r & (fall_en_r | rise_en_r);
wire lowvolt_reset_function_trip_w = det_en_r & below_rst_w & (rst_en_r | irq_func_w); // [RULE7] [RULE12]
wire hold_w = por_hold_w | lowvolt_reset_function_trip_w;

// ----------------------------------------
// AXI4-Lite slave
// ----------------------------------------
reg aw_hold_r;
reg [`ADDR_W-1:0] aw_addr_r;
reg w_hold_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
reg bvalid_r;
reg [1:0] bresp_r;
reg rvalid_r;
reg [31:0] rdata_r;
reg [1:0] rresp_r;

wire wr_go_w = aw_hold_r & w_hold_r & !bvalid_r;
wire rd_go_w = s_axi_arvalid_in & !rvalid_r;
wire [`ADDR_W-1:0] wa_w = {aw_addr_r[`ADDR_W-1:2], 2'b00};
wire [`ADDR_W-1:0] ra_w = {s_axi_araddr_in[`ADDR_W-1:2], 2'b00};
wire wr_lo_w = wr_go_w & w_strb_r[0];
wire wr_ctrl_w = wr_lo_w & (wa_w == `OFF_CTRL);
wire wr_stat_w = wr_lo_w & (wa_w == `OFF_STAT);
wire wr_evt_w = wr_lo_w & (wa_w == `OFF_EVT);
wire wr_mask_w = wr_lo_w & (wa_w == `OFF_MASK);
wire rd_stat_w = rd_go_w & (ra_w == `OFF_STAT);

always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    aw_hold_r <= 1'b0;
    aw_addr_r <= {`ADDR_W{1'b0}};
    w_hold_r <= 1'b0;
    w_data_r <= 32'h0;
    w_strb_r <= 4'h0;
    bvalid_r <= 1'b0;
    bresp_r <= `RESP_OKAY;
  end
  else
  begin
    if (s_axi_awvalid_in && !aw_hold_r)
    begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_in;
    end
    else if (wr_go_w)
      aw_hold_r <= 1'b0;
    if (s_axi_wvalid_in && !w_hold_r)
    begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata_in;
      w_strb_r <= s_axi_wstrb_in;
    end
    else if (wr_go_w)
      w_hold_r <= 1'b0;
    if (wr_go_w)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      bvalid_r <= 1'b0;
  end
end

assign s_axi_awready_out = !aw_hold_r;
assign s_axi_wready_out = !w_hold_r;
assign s_axi_bvalid_out = bvalid_r;
assign s_axi_bresp_out = bresp_r;

always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    det_en_r <= 1'b0;
    lvl_sel_r <= 1'b0;
    rst_en_r <= 1'b0;
    fall_en_r <= 1'b0;
    rise_en_r <= 1'b0;
  end
  else if (por_hold_w)
  begin
    // Detector sits in standby after power-on reset
    det_en_r <= 1'b0; // [RULE4] [RULE16]
    lvl_sel_r <= 1'b0;
    rst_en_r <= 1'b0;
    fall_en_r <= 1'b0;
    rise_en_r <= 1'b0;
  end
  else if (wr_ctrl_w)
  begin
    det_en_r <= w_data_r[`CTL_DET_EN];
    lvl_sel_r <= w_data_r[`CTL_LVL_SEL];
    rst_en_r <= w_data_r[`CTL_RST_EN];
    fall_en_r <= w_data_r[`CTL_FALL_EN];
    rise_en_r <= w_data_r[`CTL_RISE_EN];
  end
end

// ----------------------------------------
// Reset sequencer and prescaler
// ----------------------------------------
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [CNT_W-1:0] cnt_r;
reg [CNT_W-1:0] cnt_nxt;
reg ovf_r;
reg ovf_nxt;

always @*
begin
  state_nxt = state_r;
  cnt_nxt = cnt_r;
  ovf_nxt = 1'b0;
  case (state_r)
    `ST_HOLD:
    begin
      cnt_nxt = {CNT_W{1'b0}};
      if (!hold_w)
        state_nxt = `ST_COUNT; // [RULE1]
    end
    `ST_COUNT:
    begin
      if (hold_w)
      begin
        state_nxt = `ST_HOLD;
        cnt_nxt = {CNT_W{1'b0}};
      end
      else if (cnt_r == LAST_I[CNT_W-1:0])
      begin
        ovf_nxt = 1'b1; // [RULE2] [RULE8]
        state_nxt = `ST_RUN;
        cnt_nxt = {CNT_W{1'b0}};
      end
      else
        cnt_nxt = cnt_r + 1'b1;
    end
    `ST_RUN:
    begin
      if (hold_w)
        state_nxt = `ST_HOLD; // [RULE7]
    end
    default:
    begin
      state_nxt = `ST_HOLD;
      cnt_nxt = {CNT_W{1'b0}};
    end
  endcase
end

always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    state_r <= `ST_HOLD;
    cnt_r <= {CNT_W{1'b0}};
    ovf_r <= 1'b0;
  end
  else
  begin
    state_r <= state_nxt;
    cnt_r <= cnt_nxt;
    ovf_r <= ovf_nxt;
  end
end

// ----------------------------------------
// Detector events and flags
// ----------------------------------------
reg below_fall_d_r;
reg above_rise_d_r;
reg fell_r;
reg lvd_rst_n_r;
reg lvd_int_n_r;
reg fall_flag_r;
reg rise_flag_r;
reg fall_arm_r;
reg rise_arm_r;
reg line0_r;

wire fall_evt_w = det_en_r & below_fall_w & !below_fall_d_r;
// A rise only counts if the reset level was not reached meanwhile
wire rise_evt_w = det_en_r & fell_r & !below_rst_w & above_rise_w & !above_rise_d_r;
wire lowvolt_reset_function_evt_w = lowvolt_reset_function_trip_w & lvd_rst_n_r;
// Writing zero clears only a flag that was read as one
wire fall_clr_w = wr_stat_w & fall_arm_r & !w_data_r[`STA_FALL];
wire rise_clr_w = wr_stat_w & rise_arm_r & !w_data_r[`STA_RISE];

always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    below_fall_d_r <= 1'b0;
    above_rise_d_r <= 1'b0;
    fell_r <= 1'b0;
    lvd_rst_n_r <= 1'b1;
    lvd_int_n_r <= 1'b1;
    line0_r <= 1'b0;
  end
  else
  begin
    below_fall_d_r <= below_fall_w;
    above_rise_d_r <= above_rise_w;
    lvd_rst_n_r <= !lowvolt_reset_function_trip_w; // [RULE7]
    line0_r <= (fall_evt_w & fall_en_r) | (rise_evt_w & rise_en_r); // [RULE10] [RULE11]
    if (!det_en_r || below_rst_w || rise_evt_w)
      fell_r <= 1'b0;
    else if (fall_evt_w)
      fell_r <= 1'b1;
    if (!det_en_r || rise_evt_w)
      lvd_int_n_r <= 1'b1; // [RULE11]
    else if (fall_evt_w)
      lvd_int_n_r <= 1'b0; // [RULE10]
  end
end

// Flags are cleared by any chip reset, low-voltage reset included
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    fall_flag_r <= 1'b0;
    rise_flag_r <= 1'b0;
    fall_arm_r <= 1'b0;
    rise_arm_r <= 1'b0;
  end
  else if (hold_w)
  begin
    fall_flag_r <= 1'b0;
    rise_flag_r <= 1'b0;
    fall_arm_r <= 1'b0;
    rise_arm_r <= 1'b0;
  end
  else
  begin
    if (fall_evt_w)
      fall_flag_r <= 1'b1; // [RULE10]
    else if (fall_clr_w)
      fall_flag_r <= 1'b0; // [RULE17]
    if (rise_evt_w && rise_en_r)
      rise_flag_r <= 1'b1; // [RULE11]
    else if (rise_clr_w)
      rise_flag_r <= 1'b0; // [RULE17]
    if (rd_stat_w && fall_flag_r)
      fall_arm_r <= 1'b1;
    else if (wr_stat_w)
      fall_arm_r <= 1'b0;
    if (rd_stat_w && rise_flag_r)
      rise_arm_r <= 1'b1;
    else if (wr_stat_w)
      rise_arm_r <= 1'b0;
  end
end

// ----------------------------------------
// Interrupt status and mask
// ----------------------------------------
reg [`EVT_W-1:0] evt_r;
reg [`EVT_W-1:0] mask_r;
reg [`EVT_W-1:0] evt_set_w;

always @*
begin
  evt_set_w = {`EVT_W{1'b0}};
  evt_set_w[`EVT_FALL] = fall_evt_w;
  evt_set_w[`EVT_RISE] = rise_evt_w;
  evt_set_w[`EVT_LOWVOLT_RESET_FUNCTION] = lowvolt_reset_function_evt_w;
  evt_set_w[`EVT_OVF] = ovf_r;
end

// Kept through low-voltage reset so software can see its cause
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    evt_r <= {`EVT_W{1'b0}};
    mask_r <= {`EVT_W{1'b0}};
  end
  else if (por_hold_w)
  begin
    evt_r <= {`EVT_W{1'b0}};
    mask_r <= {`EVT_W{1'b0}};
  end
  else
  begin
    // Set wins over a same-cycle clear
    evt_r <= (evt_r & ~(wr_evt_w ? w_data_r[`EVT_W-1:0] : {`EVT_W{1'b0}})) | evt_set_w;
    if (wr_mask_w)
      mask_r <= w_data_r[`EVT_W-1:0];
  end
end

// ----------------------------------------
// Read path
// ----------------------------------------
reg [31:0] rd_mux_w;

always @*
begin
  rd_mux_w = 32'h0;
  case (ra_w)
    `OFF_CTRL:
    begin
      rd_mux_w[`CTL_DET_EN] = det_en_r;
      rd_mux_w[`CTL_LVL_SEL] = lvl_sel_r;
      rd_mux_w[`CTL_RST_EN] = rst_en_r;
      rd_mux_w[`CTL_FALL_EN] = fall_en_r;
      rd_mux_w[`CTL_RISE_EN] = rise_en_r;
    end
    `OFF_STAT:
      rd_mux_w[7:0] = {`STA_RSVD, fall_flag_r, rise_flag_r};
    `OFF_EVT:
      rd_mux_w[`EVT_W-1:0] = evt_r;
    `OFF_MASK:
      rd_mux_w[`EVT_W-1:0] = mask_r;
    `OFF_LEVEL:
      rd_mux_w[6:0] = {state_r[`ST_RUN_B], lvd_rst_n_r, lvd_int_n_r,
        above_rise_w, below_fall_w, below_rst_w, pin_high_w};
    default:
      rd_mux_w = 32'h0;
  endcase
end

always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    rvalid_r <= 1'b0;
    rdata_r <= 32'h0;
    rresp_r <= `RESP_OKAY;
  end
  else if (rd_go_w)
  begin
    rvalid_r <= 1'b1;
    rdata_r <= rd_mux_w;
    rresp_r <= mapped(s_axi_araddr_in) ? `RESP_OKAY : `RESP_SLVERR;
  end
  else if (s_axi_rready_in)
    rvalid_r <= 1'b0;
end

assign s_axi_arready_out = !rvalid_r;
assign s_axi_rvalid_out = rvalid_r;
assign s_axi_rdata_out = rdata_r;
assign s_axi_rresp_out = rresp_r;

// ----------------------------------------
// Outputs
// ----------------------------------------
assign internal_reset_n_out = state_r[`ST_RUN_B];
assign prescaler_overflow_out = ovf_r;
assign lowvolt_reset_n_out = lvd_rst_n_r;
assign lowvolt_int_n_out = lvd_int_n_r;
assign ext_irq_line_zero_out = line0_r;
assign detector_enable_out = det_en_r;
assign reset_level_select_out = lvl_sel_r;
assign irq_out = |(evt_r & mask_r);

endmodule

// >>> logic/por_lvd_defines.vh
// Purpose: shared constants of the reset and low-voltage supervisor
// Assumes: 125 MHz system clock, 32-bit AXI4-Lite data
// Notes: definitions only
`ifndef POR_LVD_DEFINES_VH
`define POR_LVD_DEFINES_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define PIN_FILTER_NS 100
// Least time, so round up
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESCALE_CYCLES 131072

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_EVT 8'h08
`define OFF_MASK 8'h0c
`define OFF_LEVEL 8'h10

// Control fields
`define CTL_RISE_EN 0
`define CTL_FALL_EN 1
`define CTL_RST_EN 2
`define CTL_LVL_SEL 3
`define CTL_DET_EN 4

// Status fields, bits 7 to 2 read as one
`define STA_RISE 0
`define STA_FALL 1
`define STA_RSVD 6'h3f

// Event bits of interrupt status and mask
`define EVT_W 4
`define EVT_FALL 0
`define EVT_RISE 1
`define EVT_LOWVOLT_RESET_FUNCTION 2
`define EVT_OVF 3

// Synchronised input slots
`define IN_PIN 0
`define IN_BELOW_RST 1
`define IN_BELOW_FALL 2
`define IN_ABOVE_RISE 3
`define IN_N 4

// Reset sequencer states, one-hot
`define ST_HOLD 3'h1
`define ST_COUNT 3'h2
`define ST_RUN 3'h4
`define ST_RUN_B 2

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> tb/por_lvd_asserts.sv
// Purpose: port-level checks of the reset and low-voltage supervisor
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the top module
`timescale 1ns/1ns
// ----------------------------------------
// Checker
// ----------------------------------------
module por_lvd_asserts #(
  parameter integer PRESCALE_CYCLES = 16,
  parameter integer FILTER_CYCLES = 3
)(
  input wire clk_in,
  input wire resetn_in,
  input wire ext_reset_pin_n_in,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  input wire internal_reset_n_out,
  input wire prescaler_overflow_out,
  input wire lowvolt_reset_n_out,
  input wire ext_irq_line_zero_out,
  input wire detector_enable_out
);
  // Length of the current internal reset hold and of the pin low time
  reg [31:0] low_cnt_r;
  reg [31:0] pin_low_r;
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pin_low_r <= 32'h0;
    else if (ext_reset_pin_n_in)
      pin_low_r <= 32'h0;
    else
      pin_low_r <= pin_low_r + 32'h1;
  end
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      low_cnt_r <= 32'h0;
    else if (internal_reset_n_out)
      low_cnt_r <= 32'h0;
    else
      low_cnt_r <= low_cnt_r + 32'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Three sync stages, the filter, then one edge into hold
  sequence pin_held_low;
    pin_low_r >= FILTER_CYCLES + 4;
  endsequence
  sequence lowvolt_reset_function_trip;
    $fell(lowvolt_reset_n_out);
  endsequence
  chk_pin_hold: assert property (pin_held_low |-> !internal_reset_n_out)
    else $error("internal reset released while pin held low");
  chk_ovf_release: assert property ($rose(internal_reset_n_out) |->
    prescaler_overflow_out && low_cnt_r >= PRESCALE_CYCLES)
    else $error("release without full prescaler count");
  chk_ovf_pulse: assert property (prescaler_overflow_out |=>
    !prescaler_overflow_out && internal_reset_n_out)
    else $error("overflow pulse wrong");
  chk_lowvolt_reset_function_reset: assert property (lowvolt_reset_function_trip |-> !internal_reset_n_out)
    else $error("low-voltage reset without internal reset");
  chk_lowvolt_reset_function_hold: assert property (!lowvolt_reset_n_out |-> !internal_reset_n_out)
    else $error("internal reset released during low-voltage reset");
  chk_line0_pulse: assert property (ext_irq_line_zero_out |=> !ext_irq_line_zero_out)
    else $error("line zero request longer than one cycle");
  chk_idle_quiet: assert property (!detector_enable_out [*2] |-> !ext_irq_line_zero_out)
    else $error("request while detector disabled");
  chk_read_busy: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address accepted with data pending");
endmodule

bind por_and_low_voltage_detect por_lvd_asserts #(
  .PRESCALE_CYCLES(PRESCALE_CYCLES),
  .FILTER_CYCLES(FILTER_CYCLES)
) u_chk (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .ext_reset_pin_n_in(ext_reset_pin_n_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out),
  .internal_reset_n_out(internal_reset_n_out),
  .prescaler_overflow_out(prescaler_overflow_out),
  .lowvolt_reset_n_out(lowvolt_reset_n_out),
  .ext_irq_line_zero_out(ext_irq_line_zero_out),
  .detector_enable_out(detector_enable_out)
);

// >>> tb/test_por_and_low_voltage_detect.sv
// Purpose: self-checking bench of the reset and low-voltage supervisor
// Assumes: short prescaler and filter counts
// Notes: inputs change by non-blocking assignment after rising edges
`timescale 1ns/1ns
`include "por_lvd_defines.vh"
module test_por_and_low_voltage_detect;
  localparam integer PS = 16;
  // Reference settling time of 50 us
  localparam integer SETTLE = 50000 / `CLK_PERIOD_NS;
  reg clk_in, resetn_in, pin, br, bf, up, wd, awvalid, wvalid, bready, arvalid, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rd;
  reg [1:0] rs;
  wire awready, wready, bvalid, arready, rvalid, irst_n, ovf, lvr_n, lvi_n, line0;
  wire det_en, lvl_sel, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_mismatch, checked, c;
  por_and_low_voltage_detect #(.PRESCALE_CYCLES(PS), .FILTER_CYCLES(3)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .ext_reset_pin_n_in(pin),
    .below_reset_level_in(br), .below_fall_level_in(bf), .above_rise_level_in(up),
    .watchdog_reset_in(wd), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .internal_reset_n_out(irst_n), .prescaler_overflow_out(ovf),
    .lowvolt_reset_n_out(lvr_n), .lowvolt_int_n_out(lvi_n),
    .ext_irq_line_zero_out(line0), .detector_enable_out(det_en),
    .reset_level_select_out(lvl_sel), .irq_out(irq)
  );
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task cmp_word(input [31:0] got, input [31:0] exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  end
  endtask
  task cmp_bit(input got, input exp);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  end
  endtask
  // Handshakes sampled at the falling edge, taken at the next rising one
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aw_p, w_p, b_p;
  begin
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    while (b_p)
    begin
      @(negedge clk_in);
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
      b_p = !bvalid;
      rs = bresp;
      @(posedge clk_in);
      awvalid <= aw_p;
      wvalid <= w_p;
      bready <= b_p;
    end
    cmp_word({30'h0, rs}, {30'h0, er});
  end
  endtask
  task rd_chk(input [7:0] a, input [31:0] ed, input [1:0] er);
    reg ar_p, r_p;
  begin
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_p = 1'b1;
    r_p = 1'b1;
    while (r_p)
    begin
      @(negedge clk_in);
      ar_p = ar_p && !arready;
      r_p = !rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk_in);
      arvalid <= ar_p;
      rready <= r_p;
    end
    cmp_word(rd, ed);
    cmp_word({30'h0, rs}, {30'h0, er});
  end
  endtask
  // Bounded wait: 0 release, 1 line zero request, 2 low-voltage reset
  task wait_for(input integer sel, output integer n);
  begin
    n = 0;
    @(negedge clk_in);
    while (n < 200 && !(sel == 0 ? irst_n === 1'b1 : sel == 1 ? line0 === 1'b1 : lvr_n === 1'b0))
    begin
      @(negedge clk_in);
      n = n + 1;
    end
    @(posedge clk_in);
  end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_por;
  begin
    cmp_bit(irst_n, 1'b0);
    wait_for(0, c);
    cmp_bit(c >= PS && c < 200, 1'b1);
    cmp_bit(det_en, 1'b0);
    rd_chk(`OFF_CTRL, 32'h0, `RESP_OKAY);
    rd_chk(`OFF_STAT, 32'hfc, `RESP_OKAY);
    rd_chk(8'h20, 32'h0, `RESP_SLVERR);
    wr(8'h20, 32'hff, `RESP_SLVERR);
    $display("test por done");
  end
  endtask
  task t_pin;
  begin
    pin <= 1'b0;
    repeat (2) @(posedge clk_in);
    pin <= 1'b1;
    repeat (20) @(negedge clk_in);
    cmp_bit(irst_n, 1'b1);
    @(posedge clk_in);
    pin <= 1'b0;
    repeat (12) @(negedge clk_in);
    cmp_bit(irst_n, 1'b0);
    @(posedge clk_in);
    pin <= 1'b1;
    wait_for(0, c);
    cmp_bit(c >= PS + 3 && c <= PS + 12, 1'b1);
    $display("test pin done");
  end
  endtask
  task t_lvi;
  begin
    wr(`OFF_CTRL, 32'h10, `RESP_OKAY);
    repeat (SETTLE) @(posedge clk_in);
    rd_chk(`OFF_STAT, 32'hfc, `RESP_OKAY);
    wr(`OFF_STAT, 32'h0, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h13, `RESP_OKAY);
    wr(`OFF_MASK, 32'h1, `RESP_OKAY);
    bf <= 1'b1;
    wait_for(1, c);
    cmp_bit(c < 10, 1'b1);
    cmp_bit(lvi_n, 1'b0);
    cmp_bit(irq, 1'b1);
    wr(`OFF_STAT, 32'h0, `RESP_OKAY);
    rd_chk(`OFF_STAT, 32'hfe, `RESP_OKAY);
    wr(`OFF_EVT, 32'h1, `RESP_OKAY);
    cmp_bit(irq, 1'b0);
    bf <= 1'b0;
    up <= 1'b1;
    wait_for(1, c);
    cmp_bit(c < 10, 1'b1);
    cmp_bit(lvi_n, 1'b1);
    cmp_bit(irq, 1'b0);
    rd_chk(`OFF_STAT, 32'hff, `RESP_OKAY);
    wr(`OFF_STAT, 32'h0, `RESP_OKAY);
    rd_chk(`OFF_STAT, 32'hfc, `RESP_OKAY);
    wr(`OFF_STAT, 32'hff, `RESP_OKAY);
    rd_chk(`OFF_STAT, 32'hfc, `RESP_OKAY);
    up <= 1'b0;
    wr(`OFF_CTRL, 32'h10, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
    $display("test interrupt done");
  end
  endtask
  task t_lvr;
  begin
    wr(`OFF_CTRL, 32'h10, `RESP_OKAY);
    repeat (SETTLE) @(posedge clk_in);
    wr(`OFF_STAT, 32'h0, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h1c, `RESP_OKAY);
    wr(`OFF_MASK, 32'h4, `RESP_OKAY);
    br <= 1'b1;
    wait_for(2, c);
    cmp_bit(c < 10, 1'b1);
    repeat (30) @(posedge clk_in);
    cmp_bit(irst_n, 1'b0);
    cmp_bit(irq, 1'b1);
    br <= 1'b0;
    wait_for(0, c);
    cmp_bit(c >= PS && c <= PS + 10, 1'b1);
    rd_chk(`OFF_CTRL, 32'h1c, `RESP_OKAY);
    cmp_bit(lvl_sel, 1'b1);
    wr(`OFF_EVT, 32'hc, `RESP_OKAY);
    cmp_bit(irq, 1'b0);
    wr(`OFF_CTRL, 32'h12, `RESP_OKAY);
    br <= 1'b1;
    wait_for(2, c);
    cmp_bit(c < 10, 1'b1);
    br <= 1'b0;
    wait_for(0, c);
    cmp_bit(c >= PS && c < 200, 1'b1);
    wr(`OFF_CTRL, 32'h10, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
    $display("test low-voltage reset done");
  end
  endtask
  task t_wd;
  begin
    wr(`OFF_CTRL, 32'h1c, `RESP_OKAY);
    wd <= 1'b1;
    repeat (20) @(posedge clk_in);
    wd <= 1'b0;
    cmp_bit(irst_n, 1'b0);
    wait_for(0, c);
    cmp_bit(c >= PS && c < 200, 1'b1);
    rd_chk(`OFF_CTRL, 32'h0, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h1c, `RESP_OKAY);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    cmp_bit(irst_n, 1'b0);
    resetn_in <= 1'b1;
    wait_for(0, c);
    cmp_bit(c >= PS && c < 200, 1'b1);
    rd_chk(`OFF_CTRL, 32'h0, `RESP_OKAY);
    $display("test watchdog and collapse done");
  end
  endtask
  task complete_run;
  begin
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Two settling waits dominate; the run needs about 13000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_mismatch = n_mismatch + 1;
    $display("ERROR %0t watchdog expired", $time);
    complete_run;
  end
  initial
  begin
    {resetn_in, br, bf, up, wd, awvalid, wvalid, bready, arvalid, rready} = 10'h0;
    pin = 1'b1;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    t_por;
    t_pin;
    t_lvi;
    t_lvr;
    t_wd;
    complete_run;
  end
endmodule
